// ===== src/bcsr_mbox_bank.v
// Eight 32-bit mailbox words with byte-lane writes and a write strobe per word
`timescale 1ns/1ps
`default_nettype none
`include "bcsr_regs.vh"

module bcsr_mbox_bank (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Write side
    input wire wr_en,
    input wire [`BCSR_MBOX_IDX_W-1:0] wr_idx,
    input wire [3:0] wr_be,
    input wire [31:0] wr_data,
    // Read side
    input wire [`BCSR_MBOX_IDX_W-1:0] rd_idx,
    output wire [31:0] rd_data,
    // One-cycle pulse per written word
    output reg [`BCSR_MBOX_COUNT-1:0] wr_hit
);

    reg [31:0] mbox_q [0:`BCSR_MBOX_COUNT-1];

    genvar g;
    generate
        for (g = 0; g < `BCSR_MBOX_COUNT; g = g + 1) begin : gen_word
            always @(posedge core_clk) begin
                if (!nrst) begin
                    mbox_q[g] <= `BCSR_RESET_WORD;
                end else begin
                    if (wr_en && (wr_idx == g)) begin
                        if (wr_be[0]) mbox_q[g][7:0] <= wr_data[7:0];
                        if (wr_be[1]) mbox_q[g][15:8] <= wr_data[15:8];
                        if (wr_be[2]) mbox_q[g][23:16] <= wr_data[23:16];
                        if (wr_be[3]) mbox_q[g][31:24] <= wr_data[31:24];
                    end
                end
            end
        end
    endgenerate

    // One driver for the whole strobe vector
    always @(posedge core_clk) begin
        if (!nrst) begin
            wr_hit <= 8'h00;
        end else begin
            wr_hit <= wr_en ? (8'h01 << wr_idx) : 8'h00;
        end
    end

    assign rd_data = mbox_q[rd_idx];

endmodule

`default_nettype wire

// ===== src/bcsr_regs.vh
// Offsets, field positions, reset values and sizes of the bridge register bank
//
// How it works
// RL1: Registers are reached only through the csr_access_slave memory-mapped port.
// RL2: Register space is 16 KB, split into four 4 KB sub-regions.
// RL3: 0x0000-0x0FFF holds host registers: irq enables, inbound and outbound mailboxes.
// RL4: 0x1000-0x1FFF holds outbound address translation table, writable from any side.
// RL5: 0x2000-0x2FFF is reserved; undefined addresses read as don't-care data.
// RL6: 0x3000-0x3FFF holds local registers: irq enables and both mailbox views.
// RL7: No access filtering by requester or region; any master reaches any register.
// RL8: Host irq status at 0x0040, enable at 0x0050, vector at 0x0060.
// RL9: Inbound mailboxes at 0x0800-0x081F, outbound host view at 0x0900-0x091F.
// RL10: Local irq status at 0x3060, local irq enable at 0x3070.
// RL11: Outbound mailboxes written at 0x3A00-0x3A1F, inbound read at 0x3B00-0x3B1F.
// RL12: Status bits 23:16 set on outbound mailbox 7:0 write; cleared by writing one.
// RL13: Status bits 15:0 are read-only live levels of the local irq inputs.
// RL14: Up to 16 local interrupt input lines, one per live status bit.
// RL15: Only the host should touch host irq registers; hardware does not enforce it.
// RL16: Each recorded host status condition can raise the host irq when enabled.
// RL17: Enable bits 23:16 gate mailbox flags, bits 15:0 gate local irq inputs.
// RL18: Vector register returns read-only 5-bit fabric irq vector in bits 4:0.
// RL19: Status bits 31:24 read as zero and ignore writes.
// RL20: Host irq asserted while any status bit and its enable are both set.
`ifndef BCSR_REGS_VH
`define BCSR_REGS_VH

`define BCSR_ADDR_W 14
`define BCSR_DATA_W 32
`define BCSR_REGION_LSB 12

`define BCSR_REGION_HOST 2'h0
`define BCSR_REGION_ATT 2'h1
`define BCSR_REGION_RSVD 2'h2
`define BCSR_REGION_LOCAL 2'h3

`define BCSR_HOST_IRQ_STATUS 14'h0040
`define BCSR_HOST_IRQ_ENABLE 14'h0050
`define BCSR_IRQ_VECTOR 14'h0060
`define BCSR_INBOUND_MBOX_HOST 14'h0800
`define BCSR_OUTBOUND_MBOX_HOST 14'h0900
`define BCSR_ATT_BASE 14'h1000
`define BCSR_LOCAL_IRQ_STATUS 14'h3060
`define BCSR_LOCAL_IRQ_ENABLE 14'h3070
`define BCSR_OUTBOUND_MBOX_LOCAL 14'h3a00
`define BCSR_INBOUND_MBOX_LOCAL 14'h3b00

`define BCSR_MBOX_COUNT 8
`define BCSR_MBOX_IDX_W 3
`define BCSR_MBOX_SPAN_LSB 5

`define BCSR_ATT_ENTRIES 2
`define BCSR_ATT_WORDS 4
`define BCSR_ATT_IDX_W 10

`define BCSR_MBOX_FLAG_LSB 16
`define BCSR_MBOX_FLAG_MSB 23
`define BCSR_LIVE_IRQ_W 16
`define BCSR_VECTOR_W 5

`define BCSR_RESET_WORD 32'h0000_0000
`define BCSR_RESET_FLAGS 8'h00
`define BCSR_RESET_ENABLE 24'h00_0000
`define BCSR_RESET_LIVE 16'h0000

`endif

// ===== src/bcsr_top.v
// Bridge control and status register bank with host and local interrupt status
`timescale 1ns/1ps
`default_nettype none
`include "bcsr_regs.vh"

module bcsr_top (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Register access slave
    input wire [`BCSR_ADDR_W-1:0] csr_addr,
    input wire csr_read,
    input wire csr_write,
    input wire [3:0] csr_be,
    input wire [31:0] csr_wdata,
    output reg [31:0] csr_rdata,
    output reg csr_rvalid,
    // Fabric interrupt sources
    input wire [`BCSR_LIVE_IRQ_W-1:0] local_irq_in,
    input wire [`BCSR_VECTOR_W-1:0] fabric_irq_vec,
    // Interrupt requests
    output reg host_irq,
    output reg local_irq
);

    // Address decode
    wire [1:0] region;
    wire [`BCSR_ADDR_W-1:0] word_addr;
    wire [`BCSR_ADDR_W-`BCSR_MBOX_SPAN_LSB-1:0] mbox_blk;
    wire [`BCSR_MBOX_IDX_W-1:0] mbox_idx;
    wire [`BCSR_ATT_IDX_W-1:0] att_idx;
    wire hit_host_status;
    wire hit_host_enable;
    wire hit_vector;
    wire hit_in_host;
    wire hit_out_host;
    wire hit_att;
    wire hit_local_status;
    wire hit_local_enable;
    wire hit_out_local;
    wire hit_in_local;

    assign region = csr_addr[`BCSR_ADDR_W-1:`BCSR_REGION_LSB];
    assign word_addr = {csr_addr[`BCSR_ADDR_W-1:2], 2'b00};
    assign mbox_blk = csr_addr[`BCSR_ADDR_W-1:`BCSR_MBOX_SPAN_LSB];
    assign mbox_idx = csr_addr[`BCSR_MBOX_SPAN_LSB-1:2];
    assign att_idx = csr_addr[`BCSR_REGION_LSB-1:2];

    // Full-space decode with no requester filtering, see RL2, see RL7
    assign hit_host_status = (word_addr == `BCSR_HOST_IRQ_STATUS); // see RL8
    assign hit_host_enable = (word_addr == `BCSR_HOST_IRQ_ENABLE); // see RL8
    assign hit_vector = (word_addr == `BCSR_IRQ_VECTOR); // see RL8
    assign hit_in_host =
        (mbox_blk == `BCSR_INBOUND_MBOX_HOST >> `BCSR_MBOX_SPAN_LSB); // see RL3, see RL9
    assign hit_out_host =
        (mbox_blk == `BCSR_OUTBOUND_MBOX_HOST >> `BCSR_MBOX_SPAN_LSB); // see RL3, see RL9
    assign hit_att = (region == `BCSR_REGION_ATT) &&
        (att_idx < `BCSR_ATT_WORDS); // see RL4
    assign hit_local_status = (word_addr == `BCSR_LOCAL_IRQ_STATUS); // see RL10
    assign hit_local_enable = (word_addr == `BCSR_LOCAL_IRQ_ENABLE); // see RL10
    assign hit_out_local =
        (mbox_blk == `BCSR_OUTBOUND_MBOX_LOCAL >> `BCSR_MBOX_SPAN_LSB); // see RL6, see RL11
    assign hit_in_local =
        (mbox_blk == `BCSR_INBOUND_MBOX_LOCAL >> `BCSR_MBOX_SPAN_LSB); // see RL6, see RL11

    // Byte-lane merge for plain read-write registers
    function [31:0] be_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] be;
        integer i;
        begin
            be_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) be_merge[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
    endfunction

    // Mailbox storage
    wire [31:0] in_mbox_data;
    wire [31:0] out_mbox_data;
    wire [`BCSR_MBOX_COUNT-1:0] in_mbox_hit;
    wire [`BCSR_MBOX_COUNT-1:0] out_mbox_hit;

    // Host writes inbound words, local side reads them, see RL3, see RL6
    bcsr_mbox_bank u_inbound (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(csr_write && hit_in_host),
        .wr_idx(mbox_idx),
        .wr_be(csr_be),
        .wr_data(csr_wdata),
        .rd_idx(mbox_idx),
        .rd_data(in_mbox_data),
        .wr_hit(in_mbox_hit)
    );

    // Local side writes outbound words, host reads them, see RL3, see RL6
    bcsr_mbox_bank u_outbound (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(csr_write && hit_out_local),
        .wr_idx(mbox_idx),
        .wr_be(csr_be),
        .wr_data(csr_wdata),
        .rd_idx(mbox_idx),
        .rd_data(out_mbox_data),
        .wr_hit(out_mbox_hit)
    );

    // Host and local interrupt status and enable, plus translation table storage
    reg [7:0] host_flag_q;
    reg [7:0] host_flag_d;
    reg [23:0] host_en_q;
    reg [7:0] local_flag_q;
    reg [7:0] local_flag_d;
    reg [7:0] local_en_q;
    reg [31:0] att_q [0:`BCSR_ATT_WORDS-1];
    wire [7:0] host_clr;
    wire [7:0] local_clr;
    wire [23:0] host_status_live;
    wire [31:0] host_status_word;
    wire [31:0] local_status_word;

    assign host_clr = (csr_write && hit_host_status && csr_be[2]) ?
        csr_wdata[`BCSR_MBOX_FLAG_MSB:`BCSR_MBOX_FLAG_LSB] : 8'h00;
    assign local_clr = (csr_write && hit_local_status && csr_be[2]) ?
        csr_wdata[`BCSR_MBOX_FLAG_MSB:`BCSR_MBOX_FLAG_LSB] : 8'h00;

    // Live irq inputs sit beside sticky flags, see RL13, see RL14
    assign host_status_live = {host_flag_q, local_irq_in};
    assign host_status_word = {8'h00, host_status_live}; // see RL19
    assign local_status_word = {8'h00, local_flag_q, 16'h0000};

    always @* begin
        // Set wins over write-one-to-clear, see RL12
        host_flag_d = (host_flag_q & ~host_clr) | out_mbox_hit;
        local_flag_d = (local_flag_q & ~local_clr) | in_mbox_hit;
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            host_flag_q <= `BCSR_RESET_FLAGS;
            local_flag_q <= `BCSR_RESET_FLAGS;
        end else begin
            host_flag_q <= host_flag_d; // see RL12
            local_flag_q <= local_flag_d;
        end
    end

    // Enable registers; bits 31:24 ignore writes
    wire [31:0] host_en_merged;
    assign host_en_merged = be_merge({8'h00, host_en_q}, csr_wdata, csr_be);

    always @(posedge core_clk) begin
        if (!nrst) begin
            host_en_q <= `BCSR_RESET_ENABLE;
            local_en_q <= `BCSR_RESET_FLAGS;
        end else begin
            if (csr_write && hit_host_enable) begin
                host_en_q <= host_en_merged[23:0]; // see RL17
            end
            if (csr_write && hit_local_enable && csr_be[2]) begin
                local_en_q <= csr_wdata[`BCSR_MBOX_FLAG_MSB:`BCSR_MBOX_FLAG_LSB];
            end
        end
    end

    // Translation table words, writable from any master
    integer k;
    always @(posedge core_clk) begin
        if (!nrst) begin
            for (k = 0; k < `BCSR_ATT_WORDS; k = k + 1) begin
                att_q[k] <= `BCSR_RESET_WORD;
            end
        end else if (csr_write && hit_att) begin
            att_q[att_idx[1:0]] <= be_merge(att_q[att_idx[1:0]], csr_wdata, csr_be); // see RL4
        end
    end

    // Read data mux
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000; // see RL5
        if (hit_host_status) begin
            rdata_d = host_status_word; // see RL13
        end else if (hit_host_enable) begin
            rdata_d = {8'h00, host_en_q}; // see RL17
        end else if (hit_vector) begin
            rdata_d = {27'h000_0000, fabric_irq_vec}; // see RL18
        end else if (hit_in_host || hit_in_local) begin
            rdata_d = in_mbox_data;
        end else if (hit_out_host || hit_out_local) begin
            rdata_d = out_mbox_data;
        end else if (hit_att) begin
            rdata_d = att_q[att_idx[1:0]];
        end else if (hit_local_status) begin
            rdata_d = local_status_word;
        end else if (hit_local_enable) begin
            rdata_d = {8'h00, local_en_q, 16'h0000};
        end
    end

    // One-cycle read answer from the slave port, see RL1
    always @(posedge core_clk) begin
        if (!nrst) begin
            csr_rdata <= `BCSR_RESET_WORD;
            csr_rvalid <= 1'b0;
        end else begin
            csr_rvalid <= csr_read && !csr_write;
            if (csr_read && !csr_write) begin
                csr_rdata <= rdata_d;
            end
        end
    end

    // Interrupt requests follow status and enable pairs, see RL16, see RL20
    always @(posedge core_clk) begin
        if (!nrst) begin
            host_irq <= 1'b0;
            local_irq <= 1'b0;
        end else begin
            host_irq <= |(host_status_live & host_en_q); // see RL17
            local_irq <= |(local_flag_q & local_en_q);
        end
    end

endmodule

`default_nettype wire

// ===== tb/bcsr_fabric_model.sv
// Fabric master model issuing register requests and interrupt levels
`timescale 1ns/1ps
`default_nettype none
module bcsr_fabric_model (
    // Clock
    input wire logic core_clk,
    // Requests
    output logic [13:0] csr_addr = 14'h0,
    output logic csr_read = 1'h0,
    output logic csr_write = 1'h0,
    output logic [3:0] csr_be = 4'h0,
    output logic [31:0] csr_wdata = 32'h0,
    // Answers
    input wire logic [31:0] csr_rdata,
    input wire logic csr_rvalid,
    // Interrupt sources
    output logic [15:0] local_irq_in = 16'h0,
    output logic [4:0] fabric_irq_vec = 5'h0
);
    // Any master may reach any region; host registers by convention only
    task wr(input [13:0] a, input [31:0] d, input [3:0] be);
        @(negedge core_clk);
        {csr_addr, csr_wdata, csr_be, csr_write} <= {a, d, be, 1'h1};
        @(negedge core_clk);
        {csr_addr, csr_wdata, csr_write} <= {~a, ~d, 1'h0};
        repeat (2) @(negedge core_clk);
    endtask
    task rd(input [13:0] a, output [31:0] d);
        @(negedge core_clk);
        {csr_addr, csr_read} <= {a, 1'h1};
        @(negedge core_clk);
        {csr_addr, csr_read} <= {~a, 1'h0};
        d = (csr_rvalid === 1'h1) ? csr_rdata : 32'hxxxx_xxxx;
    endtask
    task irq(input [15:0] l, input [4:0] v);
        @(negedge core_clk);
        {local_irq_in, fabric_irq_vec} <= {l, v};
    endtask
endmodule
`default_nettype wire

// ===== tb/bcsr_top_checker.sv
// Port assertions of the register bank
`timescale 1ns/1ps
`default_nettype none
module bcsr_top_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register access
    input wire logic [13:0] csr_addr,
    input wire logic csr_read,
    input wire logic csr_write,
    input wire logic [3:0] csr_be,
    input wire logic [31:0] csr_wdata,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_rvalid,
    // Interrupts
    input wire logic [15:0] local_irq_in,
    input wire logic [4:0] fabric_irq_vec,
    input wire logic host_irq,
    input wire logic local_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic rq;
    assign rq = csr_read && !csr_write;
    property p_rd_ans; rq |=> csr_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
    property p_no_ans; !rq |=> !csr_rvalid; endproperty
    a_no_ans: assert property (p_no_ans) else $error("stray answer");
    property p_hold; !rq |=> $stable(csr_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_live; rq && csr_addr == 14'h0040 |=> csr_rdata[15:0] == $past(local_irq_in);
    endproperty
    a_live: assert property (p_live) else $error("live bits wrong");
    property p_top; rq && csr_addr == 14'h0040 |=> csr_rdata[31:24] == 8'h00; endproperty
    a_top: assert property (p_top) else $error("status top bits set");
    property p_vec; rq && csr_addr == 14'h0060 |=> csr_rdata == {27'h0, $past(fabric_irq_vec)};
    endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_rsv; rq && csr_addr[13:12] == 2'h2 |=> csr_rdata == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read not zero");
    property p_hoff;
        csr_write && csr_addr == 14'h0050 && csr_be == 4'hf && csr_wdata[23:0] == 24'h0
            |-> ##3 !host_irq;
    endproperty
    a_hoff: assert property (p_hoff) else $error("host irq stays up");
    property p_loff;
        csr_write && csr_addr == 14'h3070 && csr_be[2] && csr_wdata[23:16] == 8'h0
            |-> ##3 !local_irq;
    endproperty
    a_loff: assert property (p_loff) else $error("local irq stays up");
endmodule
bind bcsr_top bcsr_top_checker i_chk (.core_clk(core_clk), .nrst(nrst), .csr_addr(csr_addr),
    .csr_read(csr_read), .csr_write(csr_write), .csr_be(csr_be), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .local_irq_in(local_irq_in),
    .fabric_irq_vec(fabric_irq_vec), .host_irq(host_irq), .local_irq(local_irq));
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the bridge register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    int error_cnt = 0;
    int checks_done = 0;
    wire [13:0] a;
    wire [31:0] wd, rdat;
    wire [15:0] li;
    wire [4:0] vec;
    wire [3:0] be;
    wire rd, wr, rv, host_irq, local_irq;
    always #10 core_clk = ~core_clk;
    bcsr_fabric_model i_fab (.core_clk(core_clk), .csr_addr(a), .csr_read(rd), .csr_write(wr),
        .csr_be(be), .csr_wdata(wd), .csr_rdata(rdat), .csr_rvalid(rv), .local_irq_in(li),
        .fabric_irq_vec(vec));
    bcsr_top i_dut (.core_clk(core_clk), .nrst(nrst), .csr_addr(a), .csr_read(rd),
        .csr_write(wr), .csr_be(be), .csr_wdata(wd), .csr_rdata(rdat), .csr_rvalid(rv),
        .local_irq_in(li), .fabric_irq_vec(vec), .host_irq(host_irq), .local_irq(local_irq));
    task end_sim;
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk(input [13:0] ad, input [31:0] e);
        logic [31:0] d;
        i_fab.rd(ad, d);
        cmp(d, e);
    endtask
    task t_reset;
        chk(14'h0040, 32'h0);
        chk(14'h0050, 32'h0);
        chk(14'h3060, 32'h0);
    endtask
    task t_outbound;
        i_fab.wr(14'h0050, 32'hffff_ffff, 4'h4);
        chk(14'h0050, 32'h00ff_0000);
        for (int i = 0; i < 8; i++) begin
            i_fab.wr(14'h3a00 + 14'(4 * i), 32'hc0de_0000 + i, 4'hf);
            chk(14'h0900 + 14'(4 * i), 32'hc0de_0000 + i);
            chk(14'h0040, 32'h1 << (16 + i));
            cmp({31'h0, host_irq}, 32'h1);
            i_fab.wr(14'h0040, 32'h1 << (16 + i), 4'hf);
            chk(14'h0040, 32'h0);
            cmp({31'h0, host_irq}, 32'h0);
        end
        i_fab.wr(14'h0050, 32'h0, 4'hf);
    endtask
    task t_live;
        logic [15:0] pat [4] = '{16'h0000, 16'h0001, 16'h8000, 16'h5a3c};
        i_fab.wr(14'h0050, 32'h0000_ffff, 4'hf);
        foreach (pat[k]) begin
            i_fab.irq(pat[k], 5'h00);
            chk(14'h0040, {16'h0, pat[k]});
            cmp({31'h0, host_irq}, {31'h0, pat[k] != 16'h0});
        end
        i_fab.wr(14'h0050, 32'h0000_a5c3, 4'hf);
        chk(14'h0050, 32'h0000_a5c3);
        cmp({31'h0, host_irq}, 32'h0);
        i_fab.irq(16'h0, 5'h00);
    endtask
    task t_vector;
        logic [4:0] v [2] = '{5'h1f, 5'h0a};
        foreach (v[k]) begin
            i_fab.irq(16'h0, v[k]);
            i_fab.wr(14'h0060, 32'hffff_ffe0, 4'hf);
            chk(14'h0060, {27'h0, v[k]});
        end
    endtask
    task t_map;
        for (int i = 0; i < 4; i++)
            i_fab.wr(14'h1000 + 14'(4 * i), 32'h5a00_0000 + i, 4'hf);
        for (int i = 0; i < 4; i++)
            chk(14'h1000 + 14'(4 * i), 32'h5a00_0000 + i);
        for (int i = 0; i < 8; i++) begin
            i_fab.wr(14'h0800 + 14'(4 * i), 32'h600d_0000 + i, 4'hf);
            chk(14'h3b00 + 14'(4 * i), 32'h600d_0000 + i);
        end
        chk(14'h3060, 32'h00ff_0000);
        i_fab.wr(14'h3070, 32'h00ff_0000, 4'h4);
        cmp({31'h0, local_irq}, 32'h1);
        i_fab.wr(14'h3070, 32'h0, 4'h4);
        cmp({31'h0, local_irq}, 32'h0);
        i_fab.wr(14'h2000, 32'hffff_ffff, 4'hf);
        chk(14'h2000, 32'h0);
        i_fab.wr(14'h0040, 32'hff00_0000, 4'hf);
        chk(14'h0040, 32'h0);
        i_fab.wr(14'h3a04, 32'h1122_3344, 4'h1);
        chk(14'h0904, 32'hc0de_0044);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'h1;
        t_reset();
        t_outbound();
        t_live();
        t_vector();
        t_map();
        end_sim();
    end
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
